// file: include/fifo_reset_regs.vh
`ifndef FIFO_RESET_REGS_VH
`define FIFO_RESET_REGS_VH

// Register byte addresses on the plain register port.
`define REG_ADDR_BITS 8
`define REG_FLAGS 8'h00
`define REG_INT_STATUS 8'h04
`define REG_INT_MASK 8'h08
`define REG_FULL_OFFSET_A 8'h0C
`define REG_EMPTY_OFFSET_B 8'h10
`define REG_FULL_OFFSET_B 8'h14
`define REG_EMPTY_OFFSET_A 8'h18

// Interrupt event bit positions.
`define EVT_COUNT 5
`define EVT_READY1 0
`define EVT_READY2 1
`define EVT_MODE1 2
`define EVT_MODE2 3
`define EVT_PROG_DONE 4
`define INT_MASK_RESET 5'h00

// Status register bit positions.
`define FLAG_STD1 0
`define FLAG_STD2 1
`define FLAG_RUN1 2
`define FLAG_RUN2 3
`define FLAG_PROG 4
`define FLAG_SEL1_LSB 8
`define FLAG_SEL2_LSB 10
`define FLAG_PINS_LSB 16

// Flag select encodings and preset offsets.
`define SEL_64 2'h3
`define SEL_16 2'h2
`define SEL_8 2'h1
`define SEL_PARALLEL 2'h0
`define PRESET_64 7'h40
`define PRESET_16 7'h10
`define PRESET_8 7'h08

// Offset register indices, in parallel load order.
`define IDX_FULL_A 2'h0
`define IDX_EMPTY_B 2'h1
`define IDX_FULL_B 2'h2
`define IDX_EMPTY_A 2'h3
`define PROG_LAST 2'h3

// Write port clock edges from reset release to input ready.
`define READY_DELAY_EDGES 2'h2

`endif

// file: rtl/pin_sync.v
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < WIDTH; bitIdx = bitIdx + 1)
        begin : stage
            reg first;
            reg second;
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    first <= 1'b0;
                    second <= 1'b0;
                end
                else
                begin
                    first <= asyncIn[bitIdx];
                    second <= first;
                end
            end
            assign syncOut[bitIdx] = second;
        end
    endgenerate

endmodule

`default_nettype wire

// file: rtl/fifo_reset_mode.v
// Behaviour
// - Reset inputs may switch asynchronously
// - Reset clears pointers, sets flag reset levels
// - Reset forces mail flag high
// - Input ready rises two clocks after release (FIFO2 waits for parallel load)
// - Reset release latches both flag selects
// - Mode pin high at next edge: standard
// - Mode pin low at next edge: fall-through
// - Standard flags show empty and full
// - Fall-through flags show output/input ready
// - First word falls through without read
// - Flag selects load preset offsets 64/16/8
// - Parallel mode: four writes load offsets
`timescale 1ns/100ps
`default_nettype none
`include "fifo_reset_regs.vh"

module fifo_reset_mode #(
    parameter ADDR_BITS = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire portAClock,
    input wire portBClock,
    input wire fifo1Reset_n,
    input wire fifo2Reset_n,
    input wire flagSelectBit0,
    input wire flagSelectBit1,
    input wire fallThroughSelect_n,
    input wire portAWriteRequest,
    input wire portAReadRequest,
    input wire portBWriteRequest,
    input wire portBReadRequest,
    input wire portAMailWrite,
    input wire portAMailRead,
    input wire portBMailWrite,
    input wire portBMailRead,
    input wire [ADDR_BITS-1:0] portAData,
    output wire portAInputReady,
    output wire portAOutputReady,
    output wire portAAlmostEmpty_n,
    output wire portAAlmostFull_n,
    output wire portBInputReady,
    output wire portBOutputReady,
    output wire portBAlmostEmpty_n,
    output wire portBAlmostFull_n,
    output wire fifo1MailFlag_n,
    output wire fifo2MailFlag_n,
    input wire [`REG_ADDR_BITS-1:0] regAddr,
    input wire [31:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regReadData,
    output reg irq
);

    localparam PIN_COUNT = 15 + ADDR_BITS;
    localparam ST_IN_RESET = 2'h0;
    localparam ST_WAIT_MODE = 2'h1;
    localparam ST_WAIT_READY = 2'h2;
    localparam ST_RUN = 2'h3;
    localparam [ADDR_BITS:0] DEPTH_COUNT = {1'b1, {ADDR_BITS{1'b0}}};

    wire [PIN_COUNT-1:0] syncPins;
    wire [ADDR_BITS-1:0] sData;
    wire sBMailRead;
    wire sBMailWrite;
    wire sAMailRead;
    wire sAMailWrite;
    wire sBRead;
    wire sBWrite;
    wire sARead;
    wire sAWrite;
    wire sModeStd;
    wire sSel1;
    wire sSel0;
    wire sReset2;
    wire sReset1;
    wire sClkB;
    wire sClkA;

    // Every FIFO-side pin crosses two flip-flops before any logic looks at it; rst_n and the register port do not.
    pin_sync #(
        .WIDTH(PIN_COUNT)
    ) pinSync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({portAData, portBMailRead, portBMailWrite, portAMailRead, portAMailWrite,
            portBReadRequest, portBWriteRequest, portAReadRequest, portAWriteRequest,
            fallThroughSelect_n, flagSelectBit1, flagSelectBit0, fifo2Reset_n,
            fifo1Reset_n, portBClock, portAClock}),
        .syncOut(syncPins)
    );

    assign {sData, sBMailRead, sBMailWrite, sAMailRead, sAMailWrite, sBRead, sBWrite,
        sARead, sAWrite, sModeStd, sSel1, sSel0, sReset2, sReset1, sClkB, sClkA} = syncPins;

    reg [1:0] clockPrev;
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            clockPrev <= 2'h0;
        else
            clockPrev <= {sClkB, sClkA};
    end

    wire edgeA = sClkA & ~clockPrev[0];
    wire edgeB = sClkB & ~clockPrev[1];

    // Channel 0 is written from port A and read on port B; channel 1 the reverse.
    wire [1:0] resetLevel = {sReset2, sReset1};
    wire [1:0] wEdge = {edgeB, edgeA};
    wire [1:0] rEdge = {edgeA, edgeB};
    wire [1:0] wReq = {sBWrite, sAWrite};
    wire [1:0] rReq = {sARead, sBRead};
    wire [1:0] mailSet = {edgeB & sBMailWrite, edgeA & sAMailWrite};
    wire [1:0] mailClear = {edgeA & sAMailRead, edgeB & sBMailRead};

    reg [ADDR_BITS-1:0] offsetReg [0:3];
    reg progActive;
    reg [1:0] progIndex;
    reg progDonePulse;

    wire [1:0] writeInhibit = {1'b0, progActive};
    wire [1:0] readyHold = {progActive, 1'b0};
    wire [1:0] chInputReady;
    wire [1:0] chOutputReady;
    wire [1:0] chAlmostEmpty_n;
    wire [1:0] chAlmostFull_n;
    wire [1:0] chMail_n;
    wire [1:0] chStdMode;
    wire [1:0] chRunning;
    wire [1:0] chWriteTry;
    wire [1:0] chRelease;
    wire [1:0] chReadyPulse;
    wire [1:0] chModePulse;
    wire [3:0] chSel;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : chan
            reg [1:0] state;
            reg [ADDR_BITS:0] writePtr;
            reg [ADDR_BITS:0] readPtr;
            reg holdValid;
            reg [1:0] edgeCount;
            reg stdMode;
            reg [1:0] selCapt;
            reg inputReady;
            reg outputReady;
            reg almostEmpty_n;
            reg almostFull_n;
            reg mail_n;
            reg releasePulse;
            reg readyPulse;
            reg modePulse;

            wire [ADDR_BITS-1:0] emptyOff = (ch == 0) ? offsetReg[`IDX_EMPTY_B]
                : offsetReg[`IDX_EMPTY_A];
            wire [ADDR_BITS-1:0] fullOff = (ch == 0) ? offsetReg[`IDX_FULL_A]
                : offsetReg[`IDX_FULL_B];
            wire [ADDR_BITS:0] stored = writePtr - readPtr;
            wire [ADDR_BITS+1:0] level = {1'b0, stored} + {{(ADDR_BITS+1){1'b0}}, holdValid};
            wire [ADDR_BITS:0] space = DEPTH_COUNT - stored;
            wire running = (state == ST_RUN);
            wire writeTry = running & wEdge[ch] & wReq[ch] & inputReady;
            wire doWrite = writeTry & ~writeInhibit[ch];
            wire readSlot = running & rEdge[ch];
            wire stdRead = readSlot & stdMode & rReq[ch] & outputReady;
            wire ftConsume = readSlot & ~stdMode & rReq[ch] & holdValid;
            wire ftLoad = readSlot & ~stdMode & (stored != {(ADDR_BITS+1){1'b0}})
                & (~holdValid | ftConsume);

            always @(posedge sys_clk)
            begin
                if (!rst_n || !resetLevel[ch])
                begin
                    state <= ST_IN_RESET;
                    writePtr <= {(ADDR_BITS+1){1'b0}};
                    readPtr <= {(ADDR_BITS+1){1'b0}};
                    holdValid <= 1'b0;
                    edgeCount <= 2'h0;
                    inputReady <= 1'b0;
                    outputReady <= 1'b0;
                    almostEmpty_n <= 1'b0;
                    almostFull_n <= 1'b1;
                    mail_n <= 1'b1;
                    releasePulse <= 1'b0;
                    readyPulse <= 1'b0;
                    modePulse <= 1'b0;
                end
                else
                begin
                    releasePulse <= 1'b0;
                    readyPulse <= 1'b0;
                    modePulse <= 1'b0;
                    // A new mail word wins over a read in the same cycle.
                    if (mailSet[ch])
                        mail_n <= 1'b0;
                    else if (mailClear[ch])
                        mail_n <= 1'b1;
                    case (state)
                        ST_IN_RESET:
                        begin
                            state <= ST_WAIT_MODE;
                            releasePulse <= 1'b1;
                        end
                        ST_WAIT_MODE:
                        begin
                            if (wEdge[ch])
                            begin
                                state <= ST_WAIT_READY;
                                modePulse <= 1'b1;
                                edgeCount <= 2'h1;
                            end
                        end
                        ST_WAIT_READY:
                        begin
                            if (wEdge[ch])
                            begin
                                edgeCount <= edgeCount + 2'h1;
                                if (edgeCount + 2'h1 == `READY_DELAY_EDGES)
                                begin
                                    state <= ST_RUN;
                                    readyPulse <= 1'b1;
                                    inputReady <= ~readyHold[ch];
                                end
                            end
                        end
                        ST_RUN:
                        begin
                            writePtr <= writePtr + {{ADDR_BITS{1'b0}}, doWrite};
                            readPtr <= readPtr + {{ADDR_BITS{1'b0}}, stdRead | ftLoad};
                            holdValid <= ftLoad | (holdValid & ~ftConsume);
                            inputReady <= ~readyHold[ch] & (stored != DEPTH_COUNT);
                            if (stdMode)
                                outputReady <= (stored != {(ADDR_BITS+1){1'b0}});
                            else
                                outputReady <= holdValid;
                            almostEmpty_n <= (level > {2'b00, emptyOff});
                            almostFull_n <= (space > {1'b0, fullOff});
                        end
                        default:
                            state <= ST_IN_RESET;
                    endcase
                end
            end

            always @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    stdMode <= 1'b1;
                    selCapt <= `SEL_PARALLEL;
                end
                else
                begin
                    if (state == ST_IN_RESET && resetLevel[ch])
                        selCapt <= {sSel1, sSel0};
                    if (state == ST_WAIT_MODE && wEdge[ch])
                        stdMode <= sModeStd;
                end
            end

            assign chInputReady[ch] = inputReady;
            assign chOutputReady[ch] = outputReady;
            assign chAlmostEmpty_n[ch] = almostEmpty_n;
            assign chAlmostFull_n[ch] = almostFull_n;
            assign chMail_n[ch] = mail_n;
            assign chStdMode[ch] = stdMode;
            assign chRunning[ch] = running;
            assign chWriteTry[ch] = writeTry;
            assign chRelease[ch] = releasePulse;
            assign chReadyPulse[ch] = readyPulse;
            assign chModePulse[ch] = modePulse;
            assign chSel[2*ch+1:2*ch] = selCapt;
        end
    endgenerate

    function [ADDR_BITS-1:0] presetValue;
        input [1:0] sel;
        begin
            presetValue = {ADDR_BITS{1'b0}};
            case (sel)
                `SEL_64: presetValue[6:0] = `PRESET_64;
                `SEL_16: presetValue[6:0] = `PRESET_16;
                `SEL_8: presetValue[6:0] = `PRESET_8;
                default: presetValue[6:0] = `PRESET_64;
            endcase
        end
    endfunction

    wire progWrite = progActive & chWriteTry[0];
    integer idx;

    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (idx = 0; idx < 4; idx = idx + 1)
                offsetReg[idx] <= presetValue(`SEL_64);
            progActive <= 1'b0;
            progIndex <= 2'h0;
            progDonePulse <= 1'b0;
        end
        else
        begin
            progDonePulse <= 1'b0;
            if (!resetLevel[0])
                progActive <= 1'b0;
            if (chRelease[0])
            begin
                if (chSel[1:0] == `SEL_PARALLEL)
                begin
                    progActive <= 1'b1;
                    progIndex <= 2'h0;
                end
                else
                begin
                    offsetReg[`IDX_FULL_A] <= presetValue(chSel[1:0]);
                    offsetReg[`IDX_EMPTY_B] <= presetValue(chSel[1:0]);
                end
            end
            if (chRelease[1] && chSel[3:2] != `SEL_PARALLEL)
            begin
                offsetReg[`IDX_FULL_B] <= presetValue(chSel[3:2]);
                offsetReg[`IDX_EMPTY_A] <= presetValue(chSel[3:2]);
            end
            if (progWrite)
            begin
                offsetReg[progIndex] <= sData;
                progIndex <= progIndex + 2'h1;
                if (progIndex == `PROG_LAST)
                begin
                    progActive <= 1'b0;
                    progDonePulse <= 1'b1;
                end
            end
        end
    end

    assign portAInputReady = chInputReady[0];
    assign portAAlmostFull_n = chAlmostFull_n[0];
    assign portBOutputReady = chOutputReady[0];
    assign portBAlmostEmpty_n = chAlmostEmpty_n[0];
    assign portBInputReady = chInputReady[1];
    assign portBAlmostFull_n = chAlmostFull_n[1];
    assign portAOutputReady = chOutputReady[1];
    assign portAAlmostEmpty_n = chAlmostEmpty_n[1];
    assign fifo1MailFlag_n = chMail_n[0];
    assign fifo2MailFlag_n = chMail_n[1];

    reg [`EVT_COUNT-1:0] intStatus;
    reg [`EVT_COUNT-1:0] intMask;
    wire [`EVT_COUNT-1:0] events = {progDonePulse, chModePulse[1], chModePulse[0],
        chReadyPulse[1], chReadyPulse[0]};
    wire [`EVT_COUNT-1:0] clearBits = (regWrite && regAddr == `REG_INT_STATUS)
        ? regWriteData[`EVT_COUNT-1:0] : {`EVT_COUNT{1'b0}};
    wire [31:0] flagsWord = {6'h00, chMail_n, chAlmostFull_n, chAlmostEmpty_n,
        chOutputReady, chInputReady, 4'h0, chSel, 3'h0, progActive, chRunning, chStdMode};

    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            intStatus <= {`EVT_COUNT{1'b0}};
            intMask <= `INT_MASK_RESET;
            irq <= 1'b0;
            regReadData <= 32'h0000_0000;
        end
        else
        begin
            // A new event outranks a clear written in the same cycle.
            intStatus <= (intStatus & ~clearBits) | events;
            if (regWrite && regAddr == `REG_INT_MASK)
                intMask <= regWriteData[`EVT_COUNT-1:0];
            irq <= |(intStatus & intMask);
            regReadData <= 32'h0000_0000;
            if (regRead)
            begin
                case (regAddr)
                    `REG_FLAGS: regReadData <= flagsWord;
                    `REG_INT_STATUS: regReadData <= {27'h000_0000, intStatus};
                    `REG_INT_MASK: regReadData <= {27'h000_0000, intMask};
                    `REG_FULL_OFFSET_A:
                        regReadData <= {{(32-ADDR_BITS){1'b0}}, offsetReg[`IDX_FULL_A]};
                    `REG_EMPTY_OFFSET_B:
                        regReadData <= {{(32-ADDR_BITS){1'b0}}, offsetReg[`IDX_EMPTY_B]};
                    `REG_FULL_OFFSET_B:
                        regReadData <= {{(32-ADDR_BITS){1'b0}}, offsetReg[`IDX_FULL_B]};
                    `REG_EMPTY_OFFSET_A:
                        regReadData <= {{(32-ADDR_BITS){1'b0}}, offsetReg[`IDX_EMPTY_A]};
                    default: regReadData <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: verification/port_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module port_host_model (
    input wire logic sys_clk,
    output var logic portAClock,
    output var logic portBClock,
    output var logic fifo1Reset_n,
    output var logic fifo2Reset_n,
    output var logic flagSelectBit0,
    output var logic flagSelectBit1,
    output var logic fallThroughSelect_n,
    output var logic [7:0] opReq,
    output var logic [7:0] portAData
);
    logic [2:0] phaseA;
    logic [3:0] phaseB;

    initial
    begin
        phaseA = 3'h0;
        phaseB = 4'h0;
        portAClock = 1'b0;
        portBClock = 1'b0;
        fifo1Reset_n = 1'b0;
        fifo2Reset_n = 1'b0;
        flagSelectBit0 = 1'b1;
        flagSelectBit1 = 1'b1;
        fallThroughSelect_n = 1'b1;
        opReq = 8'h00;
        portAData = 8'h00;
    end

    // Port clocks run free, each phase at least two sys_clk long.
    always @(posedge sys_clk)
    begin
        phaseA <= phaseA + 3'h1;
        portAClock <= phaseA[2];
        phaseB <= (phaseB == 4'h9) ? 4'h0 : phaseB + 4'h1;
        portBClock <= (phaseB > 4'h4);
    end

    task automatic resetBoth(input logic [1:0] sel, input logic mode);
        begin
            fifo1Reset_n <= 1'b0;
            fifo2Reset_n <= 1'b0;
            flagSelectBit1 <= sel[1];
            flagSelectBit0 <= sel[0];
            fallThroughSelect_n <= mode;
            repeat (60) @(posedge sys_clk);
            fifo1Reset_n <= 1'b1;
            fifo2Reset_n <= 1'b1;
        end
    endtask

    task automatic waitFall(input logic [2:0] idx);
        begin
            if (!idx[2])
                @(negedge portAClock);
            else
                @(negedge portBClock);
        end
    endtask

    // Each request spans one port clock rise; released data is scrambled.
    task automatic pinOp(input logic [2:0] idx, input logic [7:0] data);
        begin
            @(posedge sys_clk);
            waitFall(idx);
            opReq[idx] <= 1'b1;
            portAData <= data;
            waitFall(idx);
            opReq <= 8'h00;
            portAData <= ~data;
        end
    endtask
endmodule

`default_nettype wire

// file: verification/fifo_reset_mode_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "fifo_reset_regs.vh"

module fifo_reset_mode_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fifo1Reset_n,
    input wire logic fifo2Reset_n,
    input wire logic [`REG_ADDR_BITS-1:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    input wire logic irq,
    input wire logic portAInputReady,
    input wire logic portAOutputReady,
    input wire logic portAAlmostEmpty_n,
    input wire logic portAAlmostFull_n,
    input wire logic portBInputReady,
    input wire logic portBOutputReady,
    input wire logic portBAlmostEmpty_n,
    input wire logic portBAlmostFull_n,
    input wire logic fifo1MailFlag_n,
    input wire logic fifo2MailFlag_n
);
    logic [5:0] highCount1, highCount2;

    // Cycles each FIFO reset pin has stayed high, saturating.
    always @(posedge sys_clk)
    begin
        if (!rst_n || !fifo1Reset_n)
            highCount1 <= 6'h00;
        else if (highCount1 != 6'h3F)
            highCount1 <= highCount1 + 6'h01;
        if (!rst_n || !fifo2Reset_n)
            highCount2 <= 6'h00;
        else if (highCount2 != 6'h3F)
            highCount2 <= highCount2 + 6'h01;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence fifo1HeldLow;
        !fifo1Reset_n [*5];
    endsequence
    sequence fifo2HeldLow;
        !fifo2Reset_n [*5];
    endsequence
    sequence maskCleared;
        regWrite && regAddr == `REG_INT_MASK && regWriteData[4:0] == 5'h00;
    endsequence

    a_fifo1_reset_flags: assert property (fifo1HeldLow |->
        !portAInputReady && !portBOutputReady && !portBAlmostEmpty_n && portAAlmostFull_n
        && fifo1MailFlag_n) else $error("FIFO1 flags not at reset levels");
    a_fifo2_reset_flags: assert property (fifo2HeldLow |->
        !portBInputReady && !portAOutputReady && !portAAlmostEmpty_n && portBAlmostFull_n
        && fifo2MailFlag_n) else $error("FIFO2 flags not at reset levels");
    a_ready1_not_early: assert property (highCount1 != 6'h00 && highCount1 <= 6'h08 |->
        !portAInputReady) else $error("FIFO1 ready too early");
    a_ready2_not_early: assert property (highCount2 != 6'h00 && highCount2 <= 6'h0A |->
        !portBInputReady) else $error("FIFO2 ready too early");
    a_ready1_in_time: assert property (highCount1 == 6'h28 |-> portAInputReady)
        else $error("FIFO1 ready late");
    a_read_data_idle: assert property (!regRead |=> regReadData == 32'h0000_0000)
        else $error("read data outside read slot");
    a_mask_off_quiet: assert property (maskCleared |-> ##2 !irq)
        else $error("irq high with mask cleared");
    a_sys_reset_state: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |=> !irq && regReadData == 32'h0000_0000 && fifo1MailFlag_n && fifo2MailFlag_n)
        else $error("outputs not reset");
endmodule

`default_nettype wire

// file: verification/tb_fifo_reset_mode.sv
`timescale 1ns/100ps
`default_nettype none
`include "fifo_reset_regs.vh"

module tb_fifo_reset_mode;
    logic sys_clk;
    logic rst_n;
    logic [7:0] regAddr;
    logic [31:0] regWriteData;
    logic regWrite;
    logic regRead;
    wire logic portAClock, portBClock, fifo1Reset_n, fifo2Reset_n;
    wire logic flagSelectBit0, flagSelectBit1, fallThroughSelect_n;
    wire logic [7:0] opReq;
    wire logic [7:0] portAData;
    wire logic portAInputReady, portAOutputReady, portAAlmostEmpty_n, portAAlmostFull_n;
    wire logic portBInputReady, portBOutputReady, portBAlmostEmpty_n, portBAlmostFull_n;
    wire logic fifo1MailFlag_n, fifo2MailFlag_n, irq;
    wire logic [31:0] regReadData;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    int i, k;
    logic [31:0] v;
    logic [1:0] selTab [3] = '{2'h3, 2'h2, 2'h1};
    logic [31:0] presetTab [3] = '{32'h0000_0040, 32'h0000_0010, 32'h0000_0008};

    port_host_model host (
        .sys_clk, .portAClock, .portBClock, .fifo1Reset_n, .fifo2Reset_n,
        .flagSelectBit0, .flagSelectBit1, .fallThroughSelect_n, .opReq, .portAData
    );

    fifo_reset_mode #(.ADDR_BITS(8)) i_dut (
        .sys_clk, .rst_n, .portAClock, .portBClock, .fifo1Reset_n, .fifo2Reset_n,
        .flagSelectBit0, .flagSelectBit1, .fallThroughSelect_n,
        .portAWriteRequest(opReq[0]), .portAReadRequest(opReq[1]),
        .portAMailWrite(opReq[2]), .portAMailRead(opReq[3]),
        .portBWriteRequest(opReq[4]), .portBReadRequest(opReq[5]),
        .portBMailWrite(opReq[6]), .portBMailRead(opReq[7]), .portAData,
        .portAInputReady, .portAOutputReady, .portAAlmostEmpty_n, .portAAlmostFull_n,
        .portBInputReady, .portBOutputReady, .portBAlmostEmpty_n, .portBAlmostFull_n,
        .fifo1MailFlag_n, .fifo2MailFlag_n, .regAddr, .regWriteData, .regWrite, .regRead,
        .regReadData, .irq
    );

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic tally_and_finish;
        begin
            if (err_total == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            err_total++;
            tally_and_finish;
        end
    end

    task automatic checkEq(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_compared++;
            if (got !== exp)
            begin
                err_total++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic regWr(input logic [7:0] addr, input logic [31:0] data);
        begin
            regAddr <= addr;
            regWriteData <= data;
            regWrite <= 1'b1;
            @(posedge sys_clk);
            regWrite <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic regRd(input logic [7:0] addr, output logic [31:0] data);
        begin
            regAddr <= addr;
            regRead <= 1'b1;
            @(posedge sys_clk);
            regRead <= 1'b0;
            @(posedge sys_clk);
            data = regReadData;
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWriteData = 32'h0000_0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        idle(6);
        rst_n <= 1'b1;
        idle(1);
        regRd(`REG_INT_MASK, v);
        checkEq(v, 32'h0000_0000);
        regRd(8'hFC, v);
        checkEq(v, 32'h0000_0000);
        for (i = 0; i < 3; i++)
        begin
            host.resetBoth(selTab[i], ~i[0]);
            idle(60);
            for (k = 0; k < 4; k++)
            begin
                regRd(8'h0C + 8'(4 * k), v);
                checkEq(v, presetTab[i]);
            end
            regRd(`REG_FLAGS, v);
            checkEq(v & 32'h0000_0FFF, {20'h0_0000, selTab[i], selTab[i], 4'h0, 2'h3, ~i[0], ~i[0]});
            checkEq({portBInputReady, portAInputReady}, 2'h3);
            checkEq(portBOutputReady, 1'b0);
            host.pinOp(3'h0, 8'h5A);
            host.pinOp(3'h0, 8'hA5);
            idle(30);
            checkEq(portBOutputReady, 1'b1);
            checkEq({portBAlmostFull_n, portAAlmostFull_n, portAAlmostEmpty_n, portBAlmostEmpty_n}, 4'hC);
            host.pinOp(3'h5, 8'h00);
            idle(30);
            checkEq(portBOutputReady, 1'b1);
            host.pinOp(3'h5, 8'h00);
            idle(30);
            checkEq(portBOutputReady, 1'b0);
            host.pinOp(3'h4, 8'h00);
            idle(30);
            checkEq(portAOutputReady, 1'b1);
            host.pinOp(3'h1, 8'h00);
            idle(30);
            checkEq(portAOutputReady, 1'b0);
        end
        host.resetBoth(2'h0, 1'b1);
        idle(60);
        checkEq({portBInputReady, portAInputReady}, 2'h1);
        for (k = 0; k < 4; k++)
            host.pinOp(3'h0, 8'(17 * (k + 1)));
        idle(30);
        checkEq({portBOutputReady, portBInputReady}, 2'h1);
        regWr(`REG_FULL_OFFSET_A, 32'h0000_00FF);
        for (k = 0; k < 4; k++)
        begin
            regRd(8'h0C + 8'(4 * k), v);
            checkEq(v, 32'(17 * (k + 1)));
        end
        regWr(`REG_INT_STATUS, 32'h0000_001F);
        regRd(`REG_INT_STATUS, v);
        checkEq(v, 32'h0000_0000);
        host.pinOp(3'h2, 8'h00);
        host.pinOp(3'h6, 8'h00);
        idle(30);
        checkEq({fifo2MailFlag_n, fifo1MailFlag_n}, 2'h0);
        host.pinOp(3'h7, 8'h00);
        idle(30);
        checkEq({fifo2MailFlag_n, fifo1MailFlag_n}, 2'h1);
        host.pinOp(3'h2, 8'h00);
        host.resetBoth(2'h3, 1'b1);
        idle(60);
        checkEq({fifo2MailFlag_n, fifo1MailFlag_n}, 2'h3);
        regRd(`REG_INT_STATUS, v);
        checkEq(v, 32'h0000_000F);
        regWr(`REG_INT_MASK, 32'h0000_0001);
        idle(3);
        checkEq(irq, 1'b1);
        regWr(`REG_INT_STATUS, 32'h0000_0001);
        idle(3);
        checkEq(irq, 1'b0);
        regRd(`REG_INT_STATUS, v);
        checkEq(v, 32'h0000_000E);
        regRd(`REG_INT_MASK, v);
        checkEq(v, 32'h0000_0001);
        regWr(`REG_INT_MASK, 32'h0000_0000);
        idle(3);
        tally_and_finish;
    end
endmodule

bind fifo_reset_mode fifo_reset_mode_asserts u_checks (
    .sys_clk, .rst_n, .fifo1Reset_n, .fifo2Reset_n, .regAddr, .regWriteData, .regWrite,
    .regRead, .regReadData, .irq, .portAInputReady, .portAOutputReady, .portAAlmostEmpty_n,
    .portAAlmostFull_n, .portBInputReady, .portBOutputReady, .portBAlmostEmpty_n,
    .portBAlmostFull_n, .fifo1MailFlag_n, .fifo2MailFlag_n
);

`default_nettype wire
